// *** rtl/sap_bclk_gen.sv ***
// Bitclock divider for master mode
module sap_bclk_gen #(
  parameter int DIV_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [DIV_W-1:0] halfCnt,
  output logic bclk,
  output logic riseTick,
  output logic fallTick
);
  if (DIV_W < 2) begin : g_chk
    $error("DIV_W must be at least 2");
  end

  logic [DIV_W-1:0] cnt_reg;

  // Toggle every halfCnt cycles, zero acts as one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      bclk <= 1'b0;
      riseTick <= 1'b0;
      fallTick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= '0;
      bclk <= 1'b0;
      riseTick <= 1'b0;
      fallTick <= 1'b0;
    end else if (halfCnt == '0 || cnt_reg >= DIV_W'(halfCnt - 1'b1)) begin
      cnt_reg <= '0;
      bclk <= ~bclk;
      riseTick <= ~bclk;
      fallTick <= bclk;
    end else begin
      cnt_reg <= DIV_W'(cnt_reg + 1'b1);
      riseTick <= 1'b0;
      fallTick <= 1'b0;
    end
  end
endmodule // sap_bclk_gen

// *** rtl/sap_frame_formatter.sv ***
// Implementation choices: strobed register access and the register offsets.
module sap_frame_formatter #(
  parameter int DIV_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic [31:0] txData,
  input wire logic txValid,
  output logic txAck,
  output logic [31:0] rxData,
  output logic rxValid,
  output logic [3:0] rxSlot,
  input wire logic bclkIn,
  output logic bclkOut,
  output logic bclkOe,
  input wire logic fsIn,
  output logic fsOut,
  output logic fsOe,
  output logic txdOut,
  output logic txdOe,
  input wire logic rxdIn
);
  if (DIV_W < 2 || DIV_W > 8) begin : g_chk
    $error("DIV_W must lie in 2..8");
  end

  // Reset release through two flops
  logic rstMeta_reg;
  logic rstSync_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  logic rstIn_n;
  assign rstIn_n = rstSync_reg;

  sap_pkg::sap_ctrl_t ctrl_reg;
  sap_pkg::sap_frame_t frame_reg;
  sap_pkg::sap_stat_t statRd;
  logic [15:0] txTag_reg;
  logic [15:0] rxTag_reg;
  logic [19:0] rxReq_reg;
  logic underrun_reg;
  logic underrunSet;
  logic [4:0] bitIdx_reg;
  logic [3:0] slotIdx_reg;
  logic run;
  logic isMaster;

  assign run = ctrl_reg.enable;
  assign isMaster = ctrl_reg.master;

  // Software writes to configuration
  always_ff @(posedge ref_clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      ctrl_reg <= sap_pkg::SAP_CTRL_RST;
      frame_reg <= sap_pkg::SAP_FRAME_RST;
      txTag_reg <= sap_pkg::SAP_TAG_RST;
    end else if (regWrite) begin
      case (regAddr)
        sap_pkg::SAP_CTRL_OFS: ctrl_reg <= sap_pkg::sap_ctrl_t'(regWdata);
        sap_pkg::SAP_FRAME_OFS: frame_reg <= sap_pkg::sap_frame_t'(regWdata);
        sap_pkg::SAP_TAG_OFS: txTag_reg <= regWdata[15:0];
        default: ;
      endcase
    end
  end

  // Status layout view of write data, for the clear bit
  sap_pkg::sap_stat_t statWr;
  assign statWr = sap_pkg::sap_stat_t'(regWdata);

  // Sticky underrun, a new event beats the clear
  always_ff @(posedge ref_clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      underrun_reg <= 1'b0;
    end else if (underrunSet) begin
      underrun_reg <= 1'b1;
    end else if (regWrite && regAddr == sap_pkg::SAP_STAT_OFS && statWr.underrun) begin
      underrun_reg <= 1'b0;
    end
  end

  // Status view and read port
  always_comb begin
    statRd = '0;
    statRd.running = run;
    statRd.slot = slotIdx_reg;
    statRd.underrun = underrun_reg;
    statRd.rxTag = rxTag_reg;
  end
  always_ff @(posedge ref_clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regRead) begin
      case (regAddr)
        sap_pkg::SAP_CTRL_OFS: regRdata <= ctrl_reg;
        sap_pkg::SAP_FRAME_OFS: regRdata <= frame_reg;
        sap_pkg::SAP_TAG_OFS: regRdata <= {16'h0000, txTag_reg};
        sap_pkg::SAP_STAT_OFS: regRdata <= statRd;
        default: regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  // Pin inputs through synchronisers
  logic [2:0] pinSync;
  sap_sync2 #(.W(3)) u_pinSync (
    .clk(ref_clk),
    .rst_n(rstIn_n),
    .d({bclkIn, fsIn, rxdIn}),
    .q(pinSync)
  );

  // Master bitclock source
  logic genBclk;
  logic genRise;
  logic genFall;
  sap_bclk_gen #(.DIV_W(DIV_W)) u_bclkGen (
    .clk(ref_clk),
    .rst_n(rstIn_n),
    .run(run && isMaster),
    .halfCnt(frame_reg.bclkHalf[DIV_W-1:0]),
    .bclk(genBclk),
    .riseTick(genRise),
    .fallTick(genFall)
  );

  // Edge detection on the received bitclock
  logic bclkPrev_reg;
  always_ff @(posedge ref_clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      bclkPrev_reg <= 1'b0;
    end else begin
      bclkPrev_reg <= pinSync[2];
    end
  end

  // Drive and sample edges by role and polarity
  logic slvRise;
  logic slvFall;
  logic driveTick;
  logic sampleTick;
  assign slvRise = pinSync[2] & ~bclkPrev_reg;
  assign slvFall = ~pinSync[2] & bclkPrev_reg;
  assign driveTick = run & (isMaster ? genFall :
                            (ctrl_reg.bclkPol ? slvRise : slvFall));
  assign sampleTick = run & (isMaster ? genRise :
                             (ctrl_reg.bclkPol ? slvFall : slvRise));

  // Effective framing per format
  logic effLong;
  logic effDelay;
  logic effActLow;
  logic effMsb;
  logic isAc97;
  logic [3:0] slotsM1;
  always_comb begin
    effLong = ctrl_reg.fsLong;
    effDelay = ctrl_reg.fsDelay;
    effActLow = ctrl_reg.fsActLow;
    effMsb = ctrl_reg.msbFirst;
    isAc97 = 1'b0;
    slotsM1 = frame_reg.wordsM1;
    unique case (ctrl_reg.fmt)
      sap_pkg::SAP_FMT_DSP: begin
      end
      sap_pkg::SAP_FMT_I2S: begin
        effLong = 1'b1;
        effDelay = 1'b1;
        effActLow = 1'b1;
        effMsb = 1'b1;
        slotsM1 = sap_pkg::SAP_STEREO_M1;
      end
      sap_pkg::SAP_FMT_LJ: begin
        effLong = 1'b1;
        effDelay = 1'b0;
        effActLow = 1'b0;
        effMsb = 1'b1;
        slotsM1 = sap_pkg::SAP_STEREO_M1;
      end
      sap_pkg::SAP_FMT_AC97: begin
        effLong = 1'b1;
        effDelay = 1'b1;
        effActLow = 1'b0;
        effMsb = 1'b1;
        isAc97 = 1'b1;
        slotsM1 = sap_pkg::SAP_AC97_SLOTS_M1;
      end
    endcase
  end

  // Slot length and word length, less one
  function automatic logic [4:0] slotLenM1(input logic ac97, input logic [3:0] s,
                                           input logic [4:0] cfg);
    if (ac97) begin
      return (s == 4'h0) ? sap_pkg::SAP_AC97_TAG_M1 : sap_pkg::SAP_AC97_DATA_M1;
    end
    return cfg;
  endfunction
  function automatic logic [4:0] wordLenM1(input logic ac97, input logic [3:0] s,
                                           input logic [4:0] w, input logic [4:0] sl);
    if (ac97) begin
      return slotLenM1(ac97, s, sl);
    end
    return (w > sl) ? sl : w;
  endfunction

  // Slave alignment on the active frame sync edge
  logic fsPrev_reg;
  logic fsAct;
  logic alignNow;
  logic [4:0] curBit;
  logic [3:0] curSlot;
  logic [4:0] tailBit;
  assign fsAct = pinSync[1] ^ effActLow;
  assign alignNow = sampleTick & ~isMaster & fsAct & ~fsPrev_reg;
  assign tailBit = slotLenM1(isAc97, slotsM1, frame_reg.slotBitsM1);
  assign curBit = (alignNow && effDelay) ? tailBit : alignNow ? 5'h00 : bitIdx_reg;
  assign curSlot = (alignNow && effDelay) ? slotsM1 : alignNow ? 4'h0 : slotIdx_reg;
  always_ff @(posedge ref_clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      fsPrev_reg <= 1'b1;
    end else if (!run) begin
      fsPrev_reg <= 1'b1;
    end else if (sampleTick) begin
      fsPrev_reg <= fsAct;
    end
  end

  // Next bit position in the frame
  logic lastBit;
  logic [4:0] nBit;
  logic [3:0] nSlot;
  logic nextIsLast;
  assign lastBit = bitIdx_reg >= slotLenM1(isAc97, slotIdx_reg, frame_reg.slotBitsM1);
  assign nBit = lastBit ? 5'h00 : 5'(bitIdx_reg + 5'h01);
  assign nSlot = !lastBit ? slotIdx_reg :
                 (slotIdx_reg >= slotsM1) ? 4'h0 : 4'(slotIdx_reg + 4'h1);
  assign nextIsLast = nSlot == slotsM1 &&
                      nBit == slotLenM1(isAc97, nSlot, frame_reg.slotBitsM1);

  // Frame position counters
  always_ff @(posedge ref_clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      bitIdx_reg <= 5'h00;
      slotIdx_reg <= 4'h0;
    end else if (!run) begin
      bitIdx_reg <= tailBit;
      slotIdx_reg <= slotsM1;
    end else if (alignNow) begin
      bitIdx_reg <= curBit;
      slotIdx_reg <= curSlot;
    end else if (driveTick) begin
      bitIdx_reg <= nBit;
      slotIdx_reg <= nSlot;
    end
  end

  // Frame sync level for the coming bit
  logic fsNext;
  assign fsNext = effDelay ?
    (nextIsLast || (nSlot == 4'h0 && effLong &&
     nBit < slotLenM1(isAc97, 4'h0, frame_reg.slotBitsM1))) :
    (nSlot == 4'h0 && (effLong || nBit == 5'h00));

  // Transmit word selection at slot start
  logic ac97TagSlot;
  logic codecWants;
  logic wantFetch;
  logic newSlot;
  logic take;
  logic [31:0] loadWord;
  logic [31:0] txWord_reg;
  logic [31:0] word;
  logic [4:0] wM1;
  logic [4:0] bitSel;
  logic txBit;
  assign ac97TagSlot = isAc97 && nSlot == 4'h0;
  assign codecWants = nSlot < sap_pkg::SAP_AC97_REQ_FIRST ||
                      !rxReq_reg[5'(sap_pkg::SAP_AC97_REQ_BASE - {1'b0, nSlot})];
  assign wantFetch = !ac97TagSlot &&
                     (!isAc97 || (txTag_reg[4'hF - nSlot] && codecWants));
  assign newSlot = driveTick && nBit == 5'h00;
  assign take = newSlot && wantFetch && txValid;
  assign underrunSet = newSlot && wantFetch && !txValid;
  assign loadWord = ac97TagSlot ? {16'h0000, txTag_reg} :
                    take ? txData : 32'h0000_0000;
  assign word = (nBit == 5'h00) ? loadWord : txWord_reg;
  assign wM1 = wordLenM1(isAc97, nSlot, frame_reg.wordBitsM1, frame_reg.slotBitsM1);
  assign bitSel = effMsb ? 5'(wM1 - nBit) : nBit;
  assign txBit = (nBit <= wM1) & word[bitSel];

  // Transmit word holding and acknowledge
  always_ff @(posedge ref_clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      txWord_reg <= 32'h0000_0000;
      txAck <= 1'b0;
    end else begin
      txAck <= take;
      if (newSlot) begin
        txWord_reg <= loadWord;
      end
    end
  end

  // Pin drivers, changed on the drive edge and set to idle levels while stopped
  always_ff @(posedge ref_clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      fsOut <= 1'b0;
      txdOut <= 1'b0;
    end else if (!run) begin
      fsOut <= effActLow;
      txdOut <= 1'b0;
    end else if (driveTick) begin
      fsOut <= fsNext ^ effActLow;
      txdOut <= txBit;
    end
  end

  // Output enables and bitclock pin
  always_ff @(posedge ref_clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      bclkOut <= 1'b0;
      bclkOe <= 1'b0;
      fsOe <= 1'b0;
      txdOe <= 1'b0;
    end else begin
      bclkOut <= (run & isMaster & genBclk) ^ ctrl_reg.bclkPol;
      bclkOe <= run & isMaster;
      fsOe <= run & isMaster;
      txdOe <= run;
    end
  end

  // Receive shift on the sample edge
  logic [31:0] rxShift_reg;
  logic [31:0] rxBase;
  logic [31:0] rxNext;
  logic [4:0] rwM1;
  logic wordDone;
  logic rxKeep;
  assign rwM1 = wordLenM1(isAc97, curSlot, frame_reg.wordBitsM1, frame_reg.slotBitsM1);
  assign rxBase = (curBit == 5'h00) ? 32'h0000_0000 : rxShift_reg;
  assign rxNext = effMsb ? {rxBase[30:0], pinSync[0]} :
                  (rxBase | ({31'h0000_0000, pinSync[0]} << curBit));
  assign wordDone = sampleTick && curBit == rwM1;
  assign rxKeep = !isAc97 || (curSlot != 4'h0 && rxTag_reg[4'hF - curSlot]);
  always_ff @(posedge ref_clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      rxShift_reg <= 32'h0000_0000;
    end else if (sampleTick && curBit <= rwM1) begin
      rxShift_reg <= rxNext;
    end
  end

  // Incoming tag and slot request capture
  always_ff @(posedge ref_clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      rxTag_reg <= 16'h0000;
      rxReq_reg <= 20'h00000;
    end else if (!run || !isAc97) begin
      rxTag_reg <= 16'h0000;
      rxReq_reg <= 20'h00000;
    end else if (wordDone && curSlot == 4'h0) begin
      rxTag_reg <= rxNext[15:0];
    end else if (wordDone && curSlot == sap_pkg::SAP_AC97_REQ_SLOT) begin
      rxReq_reg <= rxNext[19:0];
    end
  end

  // Received words delivered with their slot number
  always_ff @(posedge ref_clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      rxData <= 32'h0000_0000;
      rxValid <= 1'b0;
      rxSlot <= 4'h0;
    end else begin
      rxValid <= 1'b0;
      if (wordDone && rxKeep) begin
        rxData <= rxNext;
        rxValid <= 1'b1;
        rxSlot <= curSlot;
      end
    end
  end
endmodule // sap_frame_formatter

// *** rtl/sap_pkg.sv ***
package sap_pkg;

  // Register byte offsets
  localparam logic [3:0] SAP_CTRL_OFS = 4'h0;
  localparam logic [3:0] SAP_FRAME_OFS = 4'h4;
  localparam logic [3:0] SAP_TAG_OFS = 4'h8;
  localparam logic [3:0] SAP_STAT_OFS = 4'hC;

  // Framing formats
  typedef enum logic [1:0] {
    SAP_FMT_DSP,
    SAP_FMT_I2S,
    SAP_FMT_LJ,
    SAP_FMT_AC97
  } sap_fmt_t;

  // Control register layout
  typedef struct packed {
    logic [22:0] rsvd;
    logic fsLong;
    logic bclkPol;
    logic fsActLow;
    logic fsDelay;
    logic msbFirst;
    sap_fmt_t fmt;
    logic master;
    logic enable;
  } sap_ctrl_t;

  // Frame geometry register layout
  typedef struct packed {
    logic [7:0] bclkHalf;
    logic [3:0] rsvd1;
    logic [3:0] wordsM1;
    logic [2:0] rsvd2;
    logic [4:0] slotBitsM1;
    logic [2:0] rsvd3;
    logic [4:0] wordBitsM1;
  } sap_frame_t;

  // Status register layout
  typedef struct packed {
    logic [6:0] rsvd1;
    logic running;
    logic [3:0] slot;
    logic [2:0] rsvd2;
    logic underrun;
    logic [15:0] rxTag;
  } sap_stat_t;

  // Values after reset
  localparam sap_ctrl_t SAP_CTRL_RST = sap_ctrl_t'(32'h0000_0010);
  localparam sap_frame_t SAP_FRAME_RST = sap_frame_t'(32'h0401_1F0F);
  localparam logic [15:0] SAP_TAG_RST = 16'h0000;

  // Fixed frame shapes
  localparam logic [3:0] SAP_STEREO_M1 = 4'h1;
  localparam logic [3:0] SAP_AC97_SLOTS_M1 = 4'hC;
  localparam logic [4:0] SAP_AC97_TAG_M1 = 5'h0F;
  localparam logic [4:0] SAP_AC97_DATA_M1 = 5'h13;
  localparam logic [3:0] SAP_AC97_REQ_SLOT = 4'h1;
  localparam logic [3:0] SAP_AC97_REQ_FIRST = 4'h3;
  localparam logic [4:0] SAP_AC97_REQ_BASE = 5'h16;

endpackage

// *** rtl/sap_sync2.sv ***
// Two-flop synchroniser for pin levels
module sap_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  if (W < 1) begin : g_chk
    $error("W must be at least 1");
  end

  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // sap_sync2

// *** verif/sap_codec_model.sv ***
module sap_codec_model (
  input wire logic drive,
  input wire logic lowAct,
  input wire logic clkPol,
  input wire logic bclkOut,
  input wire logic bclkOe,
  input wire logic fsOut,
  input wire logic fsOe,
  input wire logic txdOut,
  input wire logic txdOe,
  output logic bclkIn,
  output logic fsIn,
  output logic rxdIn,
  output logic [63:0] frame,
  output logic [8:0] frameBits,
  output int frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic genClk;
  logic [4:0] bitCnt = 5'h00;
  logic [63:0] sh = 64'h0;
  logic [8:0] n = 9'h000;
  logic prevAct = 1'b0;
  logic act;
  // Pin levels: the converter drives only what the device releases
  assign bclkIn = bclkOe ? bclkOut : genClk;
  assign fsIn = fsOe ? fsOut : (drive && bitCnt == 5'h00);
  assign rxdIn = txdOe ? txdOut : ~txdOut;
  assign act = fsIn ^ lowAct;
  // Free-running converter bitclock, phase unrelated to ref_clk
  initial begin
    genClk = 1'b0;
    #7;
    forever #80 genClk = drive ? ~genClk : 1'b0;
  end
  // Sync launched on the falling edge, 32 bits per frame
  always @(negedge genClk) bitCnt <= bitCnt + 5'h01;
  // Capture transmit data on the sampling edge, split at frame starts
  initial begin
    frames = 0;
    frame = 64'h0;
    frameBits = 9'h000;
  end
  always @(posedge (bclkIn ^ clkPol)) begin
    prevAct <= act;
    if (act && !prevAct) begin
      frame <= sh;
      frameBits <= n;
      frames <= frames + 1;
      sh <= {63'h0, txdOut};
      n <= 9'h001;
    end else begin
      sh <= {sh[62:0], txdOut};
      n <= n + 9'h001;
    end
  end
endmodule // sap_codec_model

// *** verif/sap_frame_formatter_properties.sv ***
module sap_frame_formatter_properties #(
  parameter int DIV_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic [31:0] txData,
  input wire logic txValid,
  input wire logic txAck,
  input wire logic [31:0] rxData,
  input wire logic rxValid,
  input wire logic [3:0] rxSlot,
  input wire logic bclkIn,
  input wire logic bclkOut,
  input wire logic bclkOe,
  input wire logic fsIn,
  input wire logic fsOut,
  input wire logic fsOe,
  input wire logic txdOut,
  input wire logic txdOe,
  input wire logic rxdIn
);
  timeunit 1ns;
  timeprecision 1ps;
  sap_pkg::sap_ctrl_t ctl;
  logic [7:0] half;
  logic [7:0] gap;
  logic [7:0] fsCnt;
  logic bclkPrev;
  logic primed;
  logic fsAct;
  logic [7:0] halfEff;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Zero half period behaves as one
  assign halfEff = (half == 8'h00) ? 8'h01 : half;
  assign fsAct = fsOut ^ ctl.fsActLow;
  // Shadow of the configuration software writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= sap_pkg::SAP_CTRL_RST;
      half <= sap_pkg::SAP_FRAME_RST.bclkHalf;
    end else if (regWrite && regAddr == sap_pkg::SAP_CTRL_OFS) begin
      ctl <= sap_pkg::sap_ctrl_t'(regWdata);
    end else if (regWrite && regAddr == sap_pkg::SAP_FRAME_OFS) begin
      half <= regWdata[31:24];
    end
  end
  // Cycles since last bitclock change and length of active sync
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bclkPrev <= 1'b0;
      gap <= 8'h00;
      primed <= 1'b0;
      fsCnt <= 8'h00;
    end else begin
      bclkPrev <= bclkOut;
      gap <= (bclkOut != bclkPrev) ? 8'h00 : gap + 8'h01;
      primed <= bclkOe && (primed || bclkOut != bclkPrev);
      fsCnt <= (fsAct && fsOe) ? fsCnt + 8'h01 : 8'h00;
    end
  end
  a_bclk_half: assert property (
    bclkOe && primed && bclkOut != bclkPrev |-> gap == halfEff - 8'h01)
    else $error("bitclock half period wrong");
  a_txd_edge: assert property (
    bclkOe && $past(bclkOe) && txdOe && $past(txdOe) && $stable(ctl) && $changed(txdOut)
    |-> bclkOut != bclkPrev && bclkOut == ctl.bclkPol)
    else $error("transmit bit moved off the drive edge");
  a_fs_edge: assert property (
    fsOe && $past(fsOe) && $stable(ctl) && $changed(fsOut)
    |-> bclkOut != bclkPrev && bclkOut == ctl.bclkPol)
    else $error("frame sync moved off the drive edge");
  a_oe_pair: assert property (fsOe == bclkOe)
    else $error("clock and sync enables differ");
  a_txd_oe: assert property (bclkOe |-> txdOe)
    else $error("data not driven while master");
  a_txd_quiet: assert property (!txdOe |-> !txdOut)
    else $error("data high while released");
  a_ack_pulse: assert property (txAck |=> !txAck)
    else $error("acknowledge longer than one cycle");
  a_rx_pulse: assert property (rxValid |=> !rxValid)
    else $error("receive strobe longer than one cycle");
  a_fs_short: assert property (
    fsOe && $past(fsOe, 2) && $stable(ctl) && ctl.fmt == sap_pkg::SAP_FMT_DSP && !ctl.fsLong
    && $past(fsAct) && !fsAct |-> fsCnt == {halfEff[6:0], 1'b0})
    else $error("short sync not one bitclock");
endmodule // sap_frame_formatter_properties

bind sap_frame_formatter sap_frame_formatter_properties #(.DIV_W(DIV_W))
  sap_frame_formatter_properties_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .txData(txData),
  .txValid(txValid), .txAck(txAck), .rxData(rxData), .rxValid(rxValid), .rxSlot(rxSlot),
  .bclkIn(bclkIn), .bclkOut(bclkOut), .bclkOe(bclkOe), .fsIn(fsIn), .fsOut(fsOut),
  .fsOe(fsOe), .txdOut(txdOut), .txdOe(txdOe), .rxdIn(rxdIn));

// *** verif/sap_frame_formatter_tb.sv ***
module sap_frame_formatter_tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
  localparam logic [31:0] WA = 32'h0008_C35A; // Bit 19 set: codec defers slot 3
  localparam logic [31:0] WB = 32'h0000_1E87;
  localparam logic [31:0] GEO = 32'h0401_0F0F;
  localparam logic [31:0] NONE = 32'hDEAD_BEEF;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [3:0] OC = sap_pkg::SAP_CTRL_OFS;
  localparam logic [3:0] OS = sap_pkg::SAP_STAT_OFS;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] txData = WA;
  logic txValid = 1'b1;
  logic drive = 1'b0;
  logic lowAct = 1'b0;
  logic clkPol = 1'b0;
  logic sel = 1'b0;
  logic [31:0] regRdata, rxData;
  logic txAck, rxValid, bclkIn, bclkOut, bclkOe, fsIn, fsOut, fsOe, txdOut, txdOe, rxdIn;
  logic [3:0] rxSlot;
  logic [63:0] frame;
  logic [8:0] frameBits;
  logic [31:0] rxW [16];
  int frames;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int acks = 0;
  int a0;
  sap_frame_formatter #(.DIV_W(8)) sap_frame_formatter_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .txData(txData),
    .txValid(txValid), .txAck(txAck), .rxData(rxData), .rxValid(rxValid), .rxSlot(rxSlot),
    .bclkIn(bclkIn), .bclkOut(bclkOut), .bclkOe(bclkOe), .fsIn(fsIn), .fsOut(fsOut),
    .fsOe(fsOe), .txdOut(txdOut), .txdOe(txdOe), .rxdIn(rxdIn));
  sap_codec_model sap_codec_model_inst (
    .drive(drive), .lowAct(lowAct), .clkPol(clkPol), .bclkOut(bclkOut), .bclkOe(bclkOe),
    .fsOut(fsOut), .fsOe(fsOe), .txdOut(txdOut), .txdOe(txdOe), .bclkIn(bclkIn), .fsIn(fsIn),
    .rxdIn(rxdIn), .frame(frame), .frameBits(frameBits), .frames(frames));
  always #10 ref_clk = ~ref_clk;
  // Collect received words, feed the next word on acknowledge, bound the run
  always @(posedge ref_clk) begin
    cycles++;
    if (rxValid === 1'b1) rxW[rxSlot] <= rxData;
    if (txAck === 1'b1) begin
      acks++;
      sel <= !sel;
      txData <= sel ? WA : WB;
    end
    if (cycles == 60000) begin
      failures++;
      $display("Error at %0t: timeout", $time);
      give_verdict();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(posedge ref_clk);
    `CHK(regRdata & m, e)
  endtask
  task automatic waitf(input int n);
    int k;
    k = frames + n;
    for (int i = 0; i < 30000 && frames < k; i++) @(posedge ref_clk);
  endtask
  // Stop, restart word order, set geometry and format, then enable
  task automatic cfg(input logic [31:0] c, input logic [31:0] g, input logic la);
    wr(OC, 32'h0);
    repeat (8) @(posedge ref_clk);
    sel <= 1'b0;
    txData <= WA;
    lowAct <= la;
    clkPol <= c[7];
    for (int i = 0; i < 16; i++) rxW[i] = NONE;
    wr(sap_pkg::SAP_FRAME_OFS, g);
    wr(OC, c & 32'hFFFF_FFFE);
    wr(OC, c);
  endtask
  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rev16[i] = v[15 - i];
  endfunction
  task automatic give_verdict();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(OC, ALL, 32'h0000_0010);
    rd(sap_pkg::SAP_FRAME_OFS, ALL, 32'h0401_1F0F);
    rd(sap_pkg::SAP_TAG_OFS, ALL, 32'h0);
    rd(4'h2, ALL, 32'h0);
    $display("test reset done");
    cfg(32'h0000_0013, GEO, 1'b0);
    waitf(3);
    `CHK(frame[31:0], {WA[15:0], WB[15:0]})
    `CHK(frameBits, 9'h020)
    `CHK(rxW[0], {16'h0, WA[15:0]})
    `CHK(rxW[1], {16'h0, WB[15:0]})
    `CHK(bclkOe, 1'b1)
    $display("test dsp done");
    cfg(32'h0000_01C3, GEO, 1'b1);
    waitf(3);
    `CHK(frame[31:0], {rev16(WA[15:0]), rev16(WB[15:0])})
    `CHK(rxW[0], {16'h0, WA[15:0]})
    $display("test lsb done");
    cfg(32'h0000_0033, GEO, 1'b0);
    waitf(3);
    `CHK(frame[31:0], {WB[0], WA[15:0], WB[15:1]})
    $display("test delay done");
    cfg(32'h0000_0007, 32'h0401_0F07, 1'b1);
    waitf(3);
    `CHK(frame[31:0], {1'b0, WA[7:0], 8'h00, WB[7:0], 7'h00})
    `CHK(rxW[0], {24'h0, WA[7:0]})
    $display("test i2s done");
    cfg(32'h0000_001B, GEO, 1'b0);
    waitf(3);
    `CHK(frame[31:0], {WA[15:0], WB[15:0]})
    $display("test lj done");
    txValid <= 1'b0;
    cfg(32'h0000_0013, GEO, 1'b0);
    waitf(2);
    `CHK(frame[31:0], 32'h0)
    rd(OS, 32'h0001_0000, 32'h0001_0000);
    wr(OC, 32'h0);
    wr(OS, 32'h0001_0000);
    rd(OS, 32'h0001_0000, 32'h0);
    txValid <= 1'b1;
    $display("test underrun done");
    wr(sap_pkg::SAP_TAG_OFS, 32'h0000_D000);
    cfg(32'h0000_000F, 32'h0401_1313, 1'b0);
    waitf(3);
    rd(OS, 32'h0000_FFFF, 32'h0000_D000);
    `CHK(rxW[1] == {12'h0, WA[19:0]} || rxW[1] == {12'h0, WB[19:0]}, 1'b1)
    `CHK(rxW[2], NONE)
    `CHK(rxW[3], {12'h0, WA[19:0]})
    `CHK(frameBits, 9'h100)
    $display("test ac97 done");
    cfg(32'h0000_0011, GEO, 1'b0);
    drive <= 1'b1;
    waitf(2);
    a0 = acks;
    waitf(8);
    `CHK(acks - a0, 16)
    `CHK({bclkOe, fsOe, txdOe}, 3'h1)
    rd(OS, 32'h0100_0000, 32'h0100_0000);
    drive <= 1'b0;
    $display("test slave done");
    give_verdict();
  end
endmodule // sap_frame_formatter_tb
